// ---- verilog/aca_pkg.sv ----
// Purpose: Shared constants, types and helpers for the alarm class aggregator
// Assumes: One 250 MHz system clock, synchronous active-low reset
// Notes: Command vector layout is fixed here; equations select bits of it by mask
package aca_pkg;

  localparam int ACA_NUM_CLASSES = 6;
  localparam int ACA_NUM_FLAGS = 16;
  localparam int ACA_NUM_RELAYS = 6;
  localparam int ACA_RELAY_RESERVED = 4;
  localparam int ACA_NUM_DIN = 4;
  localparam int ACA_CMD_W = 32;

  // Command vector bit positions
  localparam int ACA_CMD_CLASS_LSB = 0;
  localparam int ACA_CMD_ANY = 6;
  localparam int ACA_CMD_WARNING = 7;
  localparam int ACA_CMD_SHUTDOWN = 8;
  localparam int ACA_CMD_CENTRAL = 9;
  localparam int ACA_CMD_NEW = 10;
  localparam int ACA_CMD_HORN = 11;
  localparam int ACA_CMD_DIN_LSB = 12;
  localparam int ACA_CMD_FLAG_LSB = 16;

  // Equation slots
  localparam int ACA_EQ_FLAG_LSB = 0;
  localparam int ACA_EQ_RELAY_LSB = 16;
  localparam int ACA_EQ_EXT_ACK = 22;
  localparam int ACA_EQ_AUTO = 23;
  localparam int ACA_EQ_MANUAL = 24;
  localparam int ACA_EQ_SYNC_CHECK = 25;
  localparam int ACA_EQ_SYNC_PERM = 26;
  localparam int ACA_EQ_SYNC_RUN = 27;
  localparam int ACA_EQ_TRANS_ONE = 28;
  localparam int ACA_EQ_TRANS_TWO = 29;
  localparam int ACA_EQ_KEYLOCK = 30;
  localparam int ACA_NUM_EQ = 31;

  // Horn time unit: one second
  localparam longint ACA_CLK_HZ = 250_000_000;
  localparam int ACA_HORN_UNIT_MS = 1000;
  localparam int ACA_HORN_UNIT_CYCLES = int'(ACA_CLK_HZ * ACA_HORN_UNIT_MS / 1000);
  localparam int ACA_HORN_TIME_W = 16;
  localparam logic [31:0] ACA_PRESCALE_RST = 32'h0000_0000;
  localparam logic [ACA_HORN_TIME_W-1:0] ACA_HORN_CNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    ACA_CLS_A = 3'h0,
    ACA_CLS_B = 3'h1,
    ACA_CLS_C = 3'h2,
    ACA_CLS_D = 3'h3,
    ACA_CLS_E = 3'h4,
    ACA_CLS_F = 3'h5,
    ACA_CLS_NONE = 3'h7
  } aca_class_t;

  typedef enum logic [1:0] {
    ACA_HORN_IDLE = 2'h0,
    ACA_HORN_SOUND = 2'h1
  } aca_horn_state_t;

  typedef struct packed {
    logic [ACA_CMD_W-1:0] mask;
    logic use_and;
    logic invert;
  } aca_eq_cfg_t;

  typedef struct packed {
    logic [ACA_NUM_CLASSES-1:0] cls;
    logic any;
    logic warning;
    logic shutdown;
    logic centralized;
  } aca_alarm_group_t;

  typedef struct packed {
    logic external_ack_request;
    logic auto_mode_request;
    logic manual_mode_request;
    logic sync_check_mode_active;
    logic sync_permissive_mode_active;
    logic sync_run_mode_active;
    logic transition_alt_one_active;
    logic transition_alt_two_active;
    logic keypad_lock_active;
  } aca_mode_ind_t;

  // An empty mask reads false in either mode so an unconfigured slot stays idle
  function automatic logic aca_eval_eq(input aca_eq_cfg_t cfg, input logic [ACA_CMD_W-1:0] cmd);
    logic hit;
    hit = cfg.use_and ? &(cmd | ~cfg.mask) : |(cmd & cfg.mask);
    return (|cfg.mask) & (hit ^ cfg.invert);
  endfunction : aca_eval_eq

endpackage : aca_pkg

// ---- verilog/aca_alarm_latch.sv ----
// Purpose: Per-alarm trigger latch and per-class state reduction
// Assumes: Alarm sources come from logic on clk_sys
// Notes: A latch clears only on acknowledge once its source has gone inactive
`timescale 1ns/100ps
`default_nettype none
module aca_alarm_latch
  import aca_pkg::*;
#(
  parameter int NUM_ALARMS = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NUM_ALARMS-1:0] alarm_active,
  input wire aca_class_t alarm_class [NUM_ALARMS],
  input wire logic ack,
  output logic [ACA_NUM_CLASSES-1:0] class_state,
  output logic trigger
);

  logic [NUM_ALARMS-1:0] active_q;
  logic [NUM_ALARMS-1:0] latched;
  logic [NUM_ALARMS-1:0] rise;
  logic [NUM_ALARMS-1:0] assigned;

  // An unassigned alarm neither triggers nor latches, so it cannot sound the horn
  always_comb begin
    for (int i = 0; i < NUM_ALARMS; i++) begin
      assigned[i] = alarm_class[i] != ACA_CLS_NONE;
    end
  end

  assign rise = alarm_active & ~active_q & assigned;
  assign trigger = |rise;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      active_q <= '0;
    end else if (ce) begin
      active_q <= alarm_active;
    end
  end

  // Set wins over the acknowledge in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      latched <= '0;
    end else if (ce) begin
      latched <= rise | (latched & ~(ack ? ~alarm_active : '0));
    end
  end

  always_comb begin
    class_state = '0;
    for (int i = 0; i < NUM_ALARMS; i++) begin
      for (int c = 0; c < ACA_NUM_CLASSES; c++) begin
        if ((alarm_active[i] | latched[i]) && alarm_class[i] == aca_class_t'(c)) begin
          class_state[c] = 1'b1;
        end
      end
    end
  end

endmodule : aca_alarm_latch
`default_nettype wire

// ---- verilog/aca_horn_timer.sv ----
// Purpose: Horn output limited by a configurable time in seconds
// Assumes: horn_time is stable while counting
// Notes: A horn time of zero keeps the horn silent
`timescale 1ns/100ps
`default_nettype none
module aca_horn_timer
  import aca_pkg::*;
#(
  parameter int UNIT_CYCLES = ACA_HORN_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic trigger,
  input wire logic ack,
  input wire logic [ACA_HORN_TIME_W-1:0] horn_time,
  output logic horn
);

  aca_horn_state_t state;
  logic [31:0] prescale;
  logic [ACA_HORN_TIME_W-1:0] units;
  logic unit_end;
  logic expired;

  assign unit_end = prescale == 32'(UNIT_CYCLES - 1);
  assign expired = unit_end && (units + 16'h0001 >= horn_time);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ACA_HORN_IDLE;
    end else if (ce) begin
      case (state)
        ACA_HORN_IDLE: begin
          if (trigger && horn_time != ACA_HORN_CNT_RST) begin
            state <= ACA_HORN_SOUND;
          end
        end
        ACA_HORN_SOUND: begin
          // A fresh trigger beats acknowledge and expiry so it is never lost
          if (trigger) begin
            state <= ACA_HORN_SOUND;
          end else if (ack || expired) begin
            state <= ACA_HORN_IDLE;
          end
        end
        default: state <= ACA_HORN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prescale <= ACA_PRESCALE_RST;
      units <= ACA_HORN_CNT_RST;
    end else if (ce) begin
      if (trigger || state != ACA_HORN_SOUND) begin
        prescale <= ACA_PRESCALE_RST;
        units <= ACA_HORN_CNT_RST;
      end else if (unit_end) begin
        prescale <= ACA_PRESCALE_RST;
        units <= units + 16'h0001;
      end else begin
        prescale <= prescale + 32'h0000_0001;
      end
    end
  end

  assign horn = state == ACA_HORN_SOUND;

  if (UNIT_CYCLES < 1) begin : g_chk
    $error("UNIT_CYCLES must be at least one");
  end

endmodule : aca_horn_timer
`default_nettype wire

// ---- verilog/aca_alarm_class_aggregator.sv ----
// Purpose: Reduce alarm class states to group indications and evaluate user equations
// Assumes: Alarm sources and acknowledge come from logic on clk_sys; din_pin comes from pins
// Notes: Equations read the command vector of the previous cycle, so flags chain one cycle per hop
`timescale 1ns/100ps
`default_nettype none
module aca_alarm_class_aggregator
  import aca_pkg::*;
#(
  parameter int NUM_ALARMS = 8,
  parameter int HORN_UNIT_CYCLES = ACA_HORN_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NUM_ALARMS-1:0] alarm_active,
  input wire aca_class_t alarm_class [NUM_ALARMS],
  input wire logic ack_request,
  input wire logic [ACA_NUM_DIN-1:0] din_pin,
  input wire logic [ACA_HORN_TIME_W-1:0] horn_time,
  input wire aca_eq_cfg_t eq_cfg [ACA_NUM_EQ],
  output aca_alarm_group_t alarm_groups,
  output logic new_alarm,
  output logic horn,
  output logic [ACA_NUM_FLAGS-1:0] flags,
  output logic [ACA_NUM_RELAYS-1:0] relay,
  output aca_mode_ind_t mode_ind
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (NUM_ALARMS < 1) begin : g_chk_alarms
    $error("NUM_ALARMS must be at least one");
  end
  if (HORN_UNIT_CYCLES < 1) begin : g_chk_unit
    $error("HORN_UNIT_CYCLES must be at least one");
  end
  // Overlapping fields would let an equation read or drive the wrong bit
  if (ACA_CMD_CLASS_LSB + ACA_NUM_CLASSES > ACA_CMD_ANY) begin : g_chk_cmd_cls
    $error("Class field overlaps the group bits of the command vector");
  end
  if (ACA_CMD_HORN >= ACA_CMD_DIN_LSB) begin : g_chk_cmd_horn
    $error("Status bits overlap the pin field of the command vector");
  end
  if (ACA_CMD_DIN_LSB + ACA_NUM_DIN > ACA_CMD_FLAG_LSB) begin : g_chk_cmd_din
    $error("Pin field overlaps the flag field of the command vector");
  end
  if (ACA_CMD_FLAG_LSB + ACA_NUM_FLAGS > ACA_CMD_W) begin : g_chk_cmd_flag
    $error("Flag field does not fit the command vector");
  end
  if (ACA_EQ_FLAG_LSB + ACA_NUM_FLAGS > ACA_EQ_RELAY_LSB) begin : g_chk_eq_flag
    $error("Flag slots overlap the relay slots");
  end
  if (ACA_EQ_RELAY_LSB + ACA_NUM_RELAYS > ACA_EQ_EXT_ACK) begin : g_chk_eq_relay
    $error("Relay slots overlap the mode slots");
  end
  if (ACA_RELAY_RESERVED >= ACA_NUM_RELAYS) begin : g_chk_rsv
    $error("Reserved relay slot lies outside the relay range");
  end
  if (ACA_EQ_KEYLOCK >= ACA_NUM_EQ) begin : g_chk_eq_num
    $error("Mode slots exceed the equation count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [ACA_NUM_DIN-1:0] din_s1;
  logic [ACA_NUM_DIN-1:0] din_s2;
  logic [ACA_NUM_DIN-1:0] din_s3;
  logic [ACA_NUM_DIN-1:0] din;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      din_s1 <= '0;
      din_s2 <= '0;
      din_s3 <= '0;
    end else if (ce) begin
      din_s1 <= din_pin;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // Take a change only once the last two stages agree, to reject a metastable glitch
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      din <= '0;
    end else if (ce) begin
      for (int i = 0; i < ACA_NUM_DIN; i++) begin
        if (din_s2[i] == din_s3[i]) begin
          din[i] <= din_s3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge

  logic ack;

  // Local and external acknowledge act alike
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= ack_request | mode_ind.external_ack_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm latches and class reduction

  logic [ACA_NUM_CLASSES-1:0] class_state;
  logic trigger;

  aca_alarm_latch #(
    .NUM_ALARMS(NUM_ALARMS)
  ) u_latch (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .alarm_active(alarm_active),
    .alarm_class(alarm_class),
    .ack(ack),
    .class_state(class_state),
    .trigger(trigger)
  );

  aca_alarm_group_t next_groups;

  always_comb begin
    next_groups.cls = class_state;
    next_groups.any = |class_state;
    next_groups.warning = class_state[ACA_CLS_A] | class_state[ACA_CLS_B];
    next_groups.shutdown = class_state[ACA_CLS_C] | class_state[ACA_CLS_D]
                         | class_state[ACA_CLS_E] | class_state[ACA_CLS_F];
    next_groups.centralized = next_groups.shutdown | class_state[ACA_CLS_B];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alarm_groups <= '0;
    end else if (ce) begin
      alarm_groups <= next_groups;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // New alarm and horn

  // A trigger in the acknowledge cycle keeps the flag set
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      new_alarm <= 1'b0;
    end else if (ce) begin
      if (trigger) begin
        new_alarm <= 1'b1;
      end else if (ack) begin
        new_alarm <= 1'b0;
      end
    end
  end

  logic horn_raw;

  aca_horn_timer #(
    .UNIT_CYCLES(HORN_UNIT_CYCLES)
  ) u_horn (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .trigger(trigger),
    .ack(ack),
    .horn_time(horn_time),
    .horn(horn_raw)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      horn <= 1'b0;
    end else if (ce) begin
      horn <= horn_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command vector

  logic [ACA_CMD_W-1:0] cmd;

  // Built from registered values only, which keeps flag feedback free of loops
  always_comb begin
    cmd = '0;
    cmd[ACA_CMD_CLASS_LSB +: ACA_NUM_CLASSES] = alarm_groups.cls;
    cmd[ACA_CMD_ANY] = alarm_groups.any;
    cmd[ACA_CMD_WARNING] = alarm_groups.warning;
    cmd[ACA_CMD_SHUTDOWN] = alarm_groups.shutdown;
    cmd[ACA_CMD_CENTRAL] = alarm_groups.centralized;
    cmd[ACA_CMD_NEW] = new_alarm;
    cmd[ACA_CMD_HORN] = horn;
    cmd[ACA_CMD_DIN_LSB +: ACA_NUM_DIN] = din;
    cmd[ACA_CMD_FLAG_LSB +: ACA_NUM_FLAGS] = flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Equations

  logic [ACA_NUM_EQ-1:0] eq_out;

  always_comb begin
    for (int e = 0; e < ACA_NUM_EQ; e++) begin
      eq_out[e] = aca_eval_eq(eq_cfg[e], cmd);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags <= '0;
    end else if (ce) begin
      flags <= eq_out[ACA_EQ_FLAG_LSB +: ACA_NUM_FLAGS];
    end
  end

  logic [ACA_NUM_RELAYS-1:0] next_relay;

  always_comb begin
    next_relay = eq_out[ACA_EQ_RELAY_LSB +: ACA_NUM_RELAYS];
    next_relay[ACA_RELAY_RESERVED] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      relay <= '0;
    end else if (ce) begin
      relay <= next_relay;
    end
  end

  aca_mode_ind_t next_mode;

  always_comb begin
    next_mode.external_ack_request = eq_out[ACA_EQ_EXT_ACK];
    next_mode.auto_mode_request = eq_out[ACA_EQ_AUTO];
    next_mode.manual_mode_request = eq_out[ACA_EQ_MANUAL];
    next_mode.sync_check_mode_active = eq_out[ACA_EQ_SYNC_CHECK];
    next_mode.sync_permissive_mode_active = eq_out[ACA_EQ_SYNC_PERM];
    next_mode.sync_run_mode_active = eq_out[ACA_EQ_SYNC_RUN];
    next_mode.transition_alt_one_active = eq_out[ACA_EQ_TRANS_ONE];
    next_mode.transition_alt_two_active = eq_out[ACA_EQ_TRANS_TWO];
    next_mode.keypad_lock_active = eq_out[ACA_EQ_KEYLOCK];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_ind <= '0;
    end else if (ce) begin
      mode_ind <= next_mode;
    end
  end

endmodule : aca_alarm_class_aggregator
`default_nettype wire

// ---- dv/aca_properties.sv ----
// Purpose: Concurrent checks on the aggregator ports
// Assumes: ce held high by the bench; alarm 0 drives the trigger-side checks
// Notes: Group relations are checked every cycle since all groups come from one register stage
`timescale 1ns/100ps
`default_nettype none
module aca_properties
  import aca_pkg::*;
#(
  parameter int NUM_ALARMS = 8,
  parameter int HORN_UNIT_CYCLES = ACA_HORN_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NUM_ALARMS-1:0] alarm_active,
  input wire aca_class_t alarm_class [NUM_ALARMS],
  input wire logic ack_request,
  input wire logic [ACA_HORN_TIME_W-1:0] horn_time,
  input wire aca_alarm_group_t alarm_groups,
  input wire logic new_alarm,
  input wire logic horn,
  input wire logic [ACA_NUM_RELAYS-1:0] relay,
  input wire aca_mode_ind_t mode_ind
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_trig0;
    ce && $rose(alarm_active[0]) && alarm_class[0] != ACA_CLS_NONE;
  endsequence
  // Either acknowledge path would legally cut the horn short
  sequence s_quiet;
    ce && !ack_request && !mode_ind.external_ack_request;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_ANY: assert property (alarm_groups.any == |alarm_groups.cls)
    else $error("any-alarm does not match class states");
  AST_WARN: assert property (alarm_groups.warning == |alarm_groups.cls[1:0])
    else $error("warning group does not match classes A and B");
  AST_SHUT: assert property (alarm_groups.shutdown == |alarm_groups.cls[5:2])
    else $error("shutdown group does not match classes C to F");
  AST_CENT: assert property (alarm_groups.centralized == |alarm_groups.cls[5:1])
    else $error("centralized group does not match classes B to F");
  AST_RELAY_RSV: assert property (relay[4] == 1'b0)
    else $error("reserved relay slot driven");
  AST_CLASS_C: assert property (ce && alarm_active[0] && alarm_class[0] == ACA_CLS_C |=> alarm_groups.cls[2])
    else $error("active class C alarm not shown");
  AST_NEW_SET: assert property (s_trig0 |=> new_alarm)
    else $error("new alarm not set after trigger");
  AST_NEW_HOLD: assert property (s_quiet ##1 new_alarm |=> new_alarm)
    else $error("new alarm dropped without acknowledge");
  AST_NEW_QUIET: assert property (ce && !new_alarm && (alarm_active & ~$past(alarm_active)) == '0 |=> !new_alarm)
    else $error("new alarm set without trigger");
  AST_HORN_START: assert property (s_trig0 ##0 horn_time != '0 ##0 s_quiet ##1 s_quiet |=> horn)
    else $error("horn not sounding after trigger");
endmodule : aca_properties
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Directed bench for the alarm class aggregator
// Assumes: Horn unit shortened to 10 cycles; ce held high
// Notes: Inputs change on the falling edge so sampling never races the drivers
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %s exp=%0h got=%0h", nm, e, a); end end
module tb
  import aca_pkg::*;
();
  localparam int UNIT = 10;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] alarm_active = 8'h00;
  aca_class_t alarm_class [8];
  logic ack_request = 1'b0;
  logic [3:0] din_pin = 4'h0;
  logic [15:0] horn_time = 16'h0000;
  aca_eq_cfg_t eq_cfg [ACA_NUM_EQ];
  aca_alarm_group_t alarm_groups;
  logic new_alarm;
  logic horn;
  logic [15:0] flags;
  logic [5:0] relay;
  aca_mode_ind_t mode_ind;
  int num_errors = 0;
  int cmp_count = 0;

  aca_alarm_class_aggregator #(.NUM_ALARMS(8), .HORN_UNIT_CYCLES(UNIT)) u_dut (
    .clk_sys, .rstn, .ce, .alarm_active, .alarm_class, .ack_request, .din_pin, .horn_time,
    .eq_cfg, .alarm_groups, .new_alarm, .horn, .flags, .relay, .mode_ind);

  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic do_ack;
    ack_request = 1'b1;
    cyc(1);
    ack_request = 1'b0;
    cyc(4);
  endtask : do_ack

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_classes;
    aca_alarm_group_t exp;
    for (int c = 0; c < 6; c++) begin
      alarm_class[0] = aca_class_t'(c);
      alarm_active[0] = 1'b1;
      cyc(2);
      exp = '{cls: 6'h01 << c, any: 1'b1, warning: c < 2, shutdown: c >= 2, centralized: c >= 1};
      `CHK("groups", exp, alarm_groups)
      `CHK("new_alarm", 1'b1, new_alarm)
      alarm_active[0] = 1'b0;
      cyc(3);
      `CHK("latched", exp, alarm_groups)
      `CHK("new_held", 1'b1, new_alarm)
      `CHK("horn_zero_time", 1'b0, horn)
      do_ack();
      `CHK("cleared", 11'h000, ({alarm_groups, new_alarm}))
    end
    // Unassigned alarms must stay invisible
    alarm_class[0] = ACA_CLS_NONE;
    alarm_active[0] = 1'b1;
    cyc(3);
    `CHK("unassigned", 11'h000, ({alarm_groups, new_alarm}))
    alarm_active[0] = 1'b0;
    $display("t_classes done");
  endtask : t_classes

  task automatic t_horn;
    int cnt;
    horn_time = 16'h0003;
    alarm_class[1] = ACA_CLS_B;
    alarm_active[1] = 1'b1;
    cnt = 0;
    repeat (50) begin
      cyc(1);
      cnt += int'(horn);
    end
    // Exactly three horn units of sounding
    `CHK("horn_len", 3 * UNIT, cnt)
    alarm_class[2] = ACA_CLS_B;
    alarm_active[2] = 1'b1;
    cyc(20);
    alarm_class[3] = ACA_CLS_B;
    alarm_active[3] = 1'b1;
    cyc(25);
    `CHK("horn_restart", 1'b1, horn)
    do_ack();
    `CHK("horn_ack", 1'b0, horn)
    `CHK("new_ack", 1'b0, new_alarm)
    `CHK("active_kept", 6'h02, alarm_groups.cls)
    alarm_active = 8'h00;
    horn_time = 16'h0000;
    do_ack();
    `CHK("horn_idle", 11'h000, ({alarm_groups, new_alarm}))
    $display("t_horn done");
  endtask : t_horn

  task automatic t_eqs;
    logic [3:0] dv [3] = '{4'h3, 4'h1, 4'h0};
    logic [15:0] ef [3] = '{16'hfffb, 16'hfff3, 16'h0004};
    logic [5:0] er [3] = '{6'h2f, 6'h2f, 6'h00};
    logic [8:0] em [3] = '{9'h1ff, 9'h1ff, 9'h000};
    for (int s = 0; s < ACA_NUM_EQ; s++) begin
      eq_cfg[s] = '{mask: 32'h0000_1000, use_and: 1'b0, invert: 1'b0};
    end
    eq_cfg[1].mask = 32'h0001_0000;
    eq_cfg[2].invert = 1'b1;
    eq_cfg[3] = '{mask: 32'h0000_3000, use_and: 1'b1, invert: 1'b0};
    for (int i = 0; i < 3; i++) begin
      din_pin = dv[i];
      cyc(8);
      `CHK("flags", ef[i], flags)
      `CHK("relay", er[i], relay)
      `CHK("mode_ind", em[i], mode_ind)
    end
    // External acknowledge alone, on pin 1
    for (int s = 0; s < ACA_NUM_EQ; s++) begin
      eq_cfg[s] = '0;
    end
    eq_cfg[ACA_EQ_EXT_ACK].mask = 32'h0000_2000;
    alarm_class[4] = ACA_CLS_D;
    alarm_active[4] = 1'b1;
    cyc(2);
    alarm_active[4] = 1'b0;
    cyc(2);
    `CHK("ext_pre", 1'b1, new_alarm)
    din_pin = 4'h2;
    cyc(9);
    `CHK("ext_ack", 11'h000, ({alarm_groups, new_alarm}))
    din_pin = 4'h0;
    $display("t_eqs done");
  endtask : t_eqs
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (alarm_class[i]) begin
      alarm_class[i] = ACA_CLS_A;
    end
    foreach (eq_cfg[i]) begin
      eq_cfg[i] = '0;
    end
    cyc(2);
    `CHK("reset_out", 45'h0, ({alarm_groups, new_alarm, horn, flags, relay, mode_ind}))
    rstn = 1'b1;
    cyc(2);
    t_classes();
    t_horn();
    t_eqs();
    wrap_up();
  end

  // About twelve times the expected run length
  initial begin
    #10000;
    num_errors++;
    $display("[FAIL] watchdog expired");
    wrap_up();
  end
endmodule : tb

bind aca_alarm_class_aggregator aca_properties #(.NUM_ALARMS(NUM_ALARMS), .HORN_UNIT_CYCLES(HORN_UNIT_CYCLES)) u_props (
  .clk_sys, .rstn, .ce, .alarm_active, .alarm_class, .ack_request, .horn_time,
  .alarm_groups, .new_alarm, .horn, .relay, .mode_ind);
`default_nettype wire
